// *** rtl/blcr_config_regs.sv ***
`timescale 1ns/10ps
`include "blcr_regs.svh"
// What this block does
// - level 1 attack rate 2.5 to 500 us
// - level 1 release step 0.0625 to 6 dB
// - level 1 release rate 5 to 1000 ms
// - level 1 attenuation clamped to programmed maximum
// - battery source threshold 2.7 to 5.5 V
// - power stage threshold 5.5 to 16 V
// - hold time table, code 7 waits for clear
// - disable bit switches level 1 off
// - level 0 dwell time always zero
// - level 0 attack step codes 3 to 15
module blcr_config_regs #(
  parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire blcr_pkg::blcr_addr_t paddr,
  input  wire blcr_pkg::blcr_data_t pwdata,
  input  wire logic [3:0]         pstrb,
  output blcr_pkg::blcr_data_t    prdata,
  output logic                    pready,
  output logic                    pslverr,
  // limiter request from the gain datapath
  input  wire blcr_pkg::blcr_db_t atten_request,
  // decoded level 1 settings
  output logic [10:0]             lvl1_attack_hus,
  output blcr_pkg::blcr_val16_t   lvl1_release_step_e4db,
  output blcr_pkg::blcr_val16_t   lvl1_release_rate_ms,
  output logic [4:0]              lvl1_max_atten_db,
  output blcr_pkg::blcr_db_t      atten_limited_db,
  output blcr_pkg::blcr_val16_t   lvl1_threshold_mv,
  output blcr_pkg::blcr_val16_t   lvl1_hold_time_ms,
  output logic                    lvl1_hold_infinite,
  output logic                    lvl1_enable,
  // decoded level 0 settings
  output blcr_pkg::blcr_val16_t   lvl0_dwell_time_us,
  output blcr_pkg::blcr_val16_t   lvl0_attack_step_e4db,
  output logic                    lvl0_attack_step_valid,
  // control
  output logic                    monitor_source_select,
  output logic                    hold_clear,
  output logic                    half_us_tick,
  output logic                    ms_tick
);
  import blcr_pkg::*;

  localparam int HALF_US_CYCLES = `HALF_US_NS / `CLK_NS;

  blcr_reg_t level1_attack_release_step;
  blcr_reg_t level1_release_rate_max_atten;
  blcr_reg_t level1_voltage_threshold;
  blcr_reg_t level1_hold_and_disable;
  blcr_reg_t level0_dwell_attack_step;
  logic      ctrl_src;

  logic       setup;
  logic       wr_en;
  logic [5:0] idx;
  logic       aligned;
  logic       hit;
  blcr_data_t next_rdata;
  blcr_data_t status_word;
  logic [15:0] half_cnt;
  logic [15:0] ms_cnt;

  assign setup   = psel && !penable;
  assign pready  = psel && penable;
  // only lane 0 carries the 8-bit registers
  assign wr_en   = psel && penable && pwrite && pstrb[0];
  assign idx     = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'b00);

  assign status_word = {13'h0000, lvl0_attack_step_valid,
                        lvl1_hold_infinite, lvl1_enable,
                        lvl1_threshold_mv};

  always_comb begin
    hit        = aligned;
    next_rdata = 32'h0000_0000;
    if (!aligned) begin
      hit = 1'b0;
    end else if (idx == `IDX_L1_ATK_RLS) begin
      next_rdata = {24'h00_0000, level1_attack_release_step};
    end else if (idx == `IDX_L1_RATE_ATTN) begin
      next_rdata = {24'h00_0000, level1_release_rate_max_atten};
    end else if (idx == `IDX_L1_THRESH) begin
      next_rdata = {24'h00_0000, level1_voltage_threshold};
    end else if (idx == `IDX_L1_HOLD_DIS) begin
      next_rdata = {24'h00_0000, level1_hold_and_disable};
    end else if (idx == `IDX_L0_DWELL_ATK) begin
      next_rdata = {24'h00_0000, level0_dwell_attack_step};
    end else if (idx == `IDX_STATUS) begin
      next_rdata = status_word;
    end else if (idx == `IDX_CTRL) begin
      // hold clear is a strobe, so it always reads back as zero
      next_rdata = {31'h0000_0000, ctrl_src};
    end else begin
      hit = 1'b0;
    end
  end

  // read data and error are captured in setup so they come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= !hit || (pwrite && idx == `IDX_STATUS);
    end
  end

  // masks keep reserved positions at zero whatever is written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level1_attack_release_step    <= `RST_L1_ATK_RLS;
      level1_release_rate_max_atten <= `RST_L1_RATE_ATTN;
      level1_voltage_threshold      <= `RST_L1_THRESH;
      level1_hold_and_disable       <= `RST_L1_HOLD_DIS;
      level0_dwell_attack_step      <= `RST_L0_DWELL_ATK;
      ctrl_src                      <= 1'b0;
    end else if (wr_en && aligned) begin
      if (idx == `IDX_L1_ATK_RLS) begin
        level1_attack_release_step <= pwdata[7:0] & `WM_L1_ATK_RLS;
      end else if (idx == `IDX_L1_RATE_ATTN) begin
        level1_release_rate_max_atten <= pwdata[7:0] & `WM_L1_RATE_ATTN;
      end else if (idx == `IDX_L1_THRESH) begin
        level1_voltage_threshold <= pwdata[7:0] & `WM_L1_THRESH;
      end else if (idx == `IDX_L1_HOLD_DIS) begin
        level1_hold_and_disable <= pwdata[7:0] & `WM_L1_HOLD_DIS;
      end else if (idx == `IDX_L0_DWELL_ATK) begin
        level0_dwell_attack_step <= pwdata[7:0] & `WM_L0_DWELL_ATK;
      end else if (idx == `IDX_CTRL) begin
        ctrl_src <= pwdata[`F_SRC];
      end
    end
  end

  // one-cycle strobe that releases an indefinite hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_clear <= 1'b0;
    end else begin
      hold_clear <= wr_en && aligned && idx == `IDX_CTRL
                    && pwdata[`F_HCLR];
    end
  end

  // time bases for the limiter; ms divider is long, so it is a parameter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt     <= 16'h0000;
      half_us_tick <= 1'b0;
    end else if (half_cnt == 16'(HALF_US_CYCLES - 1)) begin
      half_cnt     <= 16'h0000;
      half_us_tick <= 1'b1;
    end else begin
      half_cnt     <= half_cnt + 16'h0001;
      half_us_tick <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt  <= 16'h0000;
      ms_tick <= 1'b0;
    end else if (ms_cnt == 16'(MS_CYCLES - 1)) begin
      ms_cnt  <= 16'h0000;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + 16'h0001;
      ms_tick <= 1'b0;
    end
  end

  // decode of the stored codes
  logic [2:0]  atk_code;
  logic [3:0]  rls_code;
  logic [2:0]  rate_code;
  logic [4:0]  attn_code;
  logic [7:0]  th_code;
  logic [2:0]  hold_code;
  logic [3:0]  l0_code;
  logic [19:0] atk_ns;
  blcr_val16_t th_mv;
  logic [159:0] atk_tbl;
  logic [255:0] step_tbl;
  logic [127:0] rls_tbl;
  logic [127:0] hold_tbl;

  assign atk_tbl   = `ATK_NS_TBL;
  assign step_tbl  = `STEP_TBL;
  assign rls_tbl   = `RLS_MS_TBL;
  assign hold_tbl  = `HOLD_MS_TBL;
  assign atk_code  = level1_attack_release_step[`F_TOP3];
  assign rls_code  = level1_attack_release_step[`F_STEP];
  assign rate_code = level1_release_rate_max_atten[`F_TOP3];
  assign attn_code = level1_release_rate_max_atten[`F_ATTN];
  assign th_code   = level1_voltage_threshold;
  assign hold_code = level1_hold_and_disable[`F_TOP3];
  assign l0_code   = level0_dwell_attack_step[`F_STEP];
  assign atk_ns    = atk_tbl[atk_code * 20 +: 20];

  // out-of-range threshold codes read as 0 V
  always_comb begin
    th_mv = 16'h0000;
    if (!ctrl_src) begin
      if (th_code <= `TH_BAT_MAX) begin
        th_mv = `TH_BAT_BASE_MV + 16'(th_code) * `TH_STEP_MV;
      end
    end else if (th_code <= `TH_PWR_MAX) begin
      th_mv = `TH_PWR_BASE_MV + 16'(th_code) * `TH_STEP_MV;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl1_attack_hus        <= 11'h000;
      lvl1_release_step_e4db <= 16'h0000;
      lvl1_release_rate_ms   <= 16'h0000;
      lvl1_max_atten_db      <= 5'h00;
      lvl1_threshold_mv      <= 16'h0000;
      lvl1_hold_time_ms      <= 16'h0000;
      lvl1_hold_infinite     <= 1'b0;
      lvl1_enable            <= 1'b0;
      lvl0_dwell_time_us     <= 16'h0000;
      lvl0_attack_step_e4db  <= 16'h0000;
      lvl0_attack_step_valid <= 1'b0;
      monitor_source_select  <= 1'b0;
    end else begin
      lvl1_attack_hus <= 11'(atk_ns / 20'(`HALF_US_NS));
      lvl1_release_step_e4db <= step_tbl[rls_code * 16 +: 16];
      lvl1_release_rate_ms <= rls_tbl[rate_code * 16 +: 16];
      lvl1_max_atten_db <= attn_code;
      lvl1_threshold_mv <= th_mv;
      lvl1_hold_time_ms <= hold_tbl[hold_code * 16 +: 16];
      lvl1_hold_infinite <= (hold_code == `HOLD_INF_CODE);
      lvl1_enable <= !level1_hold_and_disable[`F_DIS];
      // the dwell field is stored for readback only
      lvl0_dwell_time_us <= `DWELL0_US;
      lvl0_attack_step_valid <= (l0_code >= `L0_ATK_MIN_CODE);
      lvl0_attack_step_e4db <= (l0_code >= `L0_ATK_MIN_CODE) ?
                               step_tbl[l0_code * 16 +: 16] :
                               16'h0000;
      monitor_source_select <= ctrl_src;
    end
  end

  // combinational clamp so the limiter sees no added latency
  always_comb begin
    if (!lvl1_enable) begin
      atten_limited_db = 6'h00;
    end else if (atten_request > {1'b0, lvl1_max_atten_db}) begin
      atten_limited_db = {1'b0, lvl1_max_atten_db};
    end else begin
      atten_limited_db = atten_request;
    end
  end

  // checks; decoded outputs lag their codes by one edge, and the first
  // edge after reset still shows reset values, hence the past reset term
  a_attack_decode: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $past(atk_code) == 3'h0
    |-> lvl1_attack_hus == 11'h005)
    else $error("attack code 0 not decoded to 2.5 us");
  a_attack_max: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $past(atk_code) == 3'h7
    |-> lvl1_attack_hus == 11'h3e8)
    else $error("attack code 7 not decoded to 500 us");
  a_release_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $past(rls_code) == 4'hf
    |-> lvl1_release_step_e4db == 16'hea60)
    else $error("release step code 15 not 6 dB");
  a_step_min: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $past(rls_code) == 4'h0
    |-> lvl1_release_step_e4db == 16'h0271)
    else $error("release step code 0 not 0.0625 dB");
  a_release_rate: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $past(rate_code) == 3'h7
    |-> lvl1_release_rate_ms == 16'h03e8)
    else $error("release rate code 7 not 1000 ms");
  a_atten_clamp: assert property (
    @(posedge pclk) disable iff (!presetn)
    atten_limited_db <= {1'b0, lvl1_max_atten_db})
    else $error("attenuation exceeds programmed maximum");
  a_bat_thresh: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && !$past(ctrl_src) && $past(th_code) > `TH_BAT_MAX
    |-> lvl1_threshold_mv == 16'h0000)
    else $error("battery threshold above 5.5 V not zero");
  a_pwr_thresh: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $past(ctrl_src) && $past(th_code) == `TH_PWR_MAX
    |-> lvl1_threshold_mv == 16'h3e80)
    else $error("supply threshold code D2h not 16 V");
  a_hold_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    hold_clear |=> !hold_clear || $past(wr_en))
    else $error("hold clear longer than one cycle");
  a_hold_cause: assert property (
    @(posedge pclk) disable iff (!presetn)
    hold_clear |-> $past(wr_en) && $past(idx) == `IDX_CTRL)
    else $error("hold clear without a control write");
  a_hold_infinite: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $past(hold_code) == `HOLD_INF_CODE
    |-> lvl1_hold_infinite && lvl1_hold_time_ms == 16'hffff)
    else $error("hold code 7 not marked indefinite");
  a_disable_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(level1_hold_and_disable[`F_DIS]) |-> !lvl1_enable
    ##0 atten_limited_db == 6'h00)
    else $error("level 1 still active while disabled");
  a_dwell_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    lvl0_dwell_time_us == 16'h0000)
    else $error("level 0 dwell time not zero");
  a_l0_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(l0_code) < `L0_ATK_MIN_CODE |-> !lvl0_attack_step_valid
    && lvl0_attack_step_e4db == 16'h0000)
    else $error("undefined level 0 step marked valid");
  a_reserved_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == 8'hb4 |=> prdata[3:0] == 4'h0)
    else $error("reserved bits read non-zero");
  a_read_upper: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && idx != `IDX_STATUS |=> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits of a register not zero");
  a_reserved_bits: assert property (
    @(posedge pclk) disable iff (!presetn)
    level1_hold_and_disable[3:0] == 4'h0 && !level1_attack_release_step[0]
    && !level0_dwell_attack_step[0])
    else $error("reserved register bit holds a one");

  c_write_then_read: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en ##2 setup && !pwrite);
  c_hold_clear: cover property (@(posedge pclk) disable iff (!presetn)
    lvl1_hold_infinite && hold_clear);
  c_pwr_source: cover property (@(posedge pclk) disable iff (!presetn)
    monitor_source_select && lvl1_threshold_mv != 16'h0000);
  c_clamp_active: cover property (@(posedge pclk) disable iff (!presetn)
    lvl1_enable && atten_request > {1'b0, lvl1_max_atten_db});
  c_status_read: cover property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && idx == `IDX_STATUS);
endmodule

// *** rtl/blcr_pkg.sv ***
package blcr_pkg;
  typedef logic [7:0]  blcr_addr_t;
  typedef logic [31:0] blcr_data_t;
  typedef logic [7:0]  blcr_reg_t;
  typedef logic [15:0] blcr_val16_t;
  typedef logic [5:0]  blcr_db_t;
endpackage

// *** rtl/blcr_regs.svh ***
`ifndef BLCR_REGS_SVH
`define BLCR_REGS_SVH
// register indices; byte address is the index shifted left by two
`define IDX_L1_ATK_RLS   6'h2a
`define IDX_L1_RATE_ATTN 6'h2b
`define IDX_L1_THRESH    6'h2c
`define IDX_L1_HOLD_DIS  6'h2d
`define IDX_L0_DWELL_ATK 6'h2e
`define IDX_STATUS       6'h3e
`define IDX_CTRL         6'h3f
// reset values
`define RST_L1_ATK_RLS   8'h06
`define RST_L1_RATE_ATTN 8'h38
`define RST_L1_THRESH    8'h40
`define RST_L1_HOLD_DIS  8'h20
`define RST_L0_DWELL_ATK 8'h02
// writable bits; the rest are reserved and read as zero
`define WM_L1_ATK_RLS    8'hfe
`define WM_L1_RATE_ATTN  8'hff
`define WM_L1_THRESH     8'hff
`define WM_L1_HOLD_DIS   8'hf0
`define WM_L0_DWELL_ATK  8'hfe
// field positions
`define F_TOP3           7:5
`define F_STEP           4:1
`define F_ATTN           4:0
`define F_DIS            4
`define F_SRC            0
`define F_HCLR           1
`define S_TH             15:0
`define S_EN             16
`define S_HINF           17
`define S_L0V            18
// timing in ns
`define CLK_NS           32'h0000_0014
`define HALF_US_NS       32'h0000_01f4
`define MS_NS            32'h000f_4240
// attack time in ns, code 7 first
`define ATK_NS_TBL {20'h7_a120, 20'h3_d090, 20'h1_86a0, 20'h0_c350, \
                    20'h0_61a8, 20'h0_2710, 20'h0_1388, 20'h0_09c4}
// step size in units of 0.0001 dB, code 15 first
`define STEP_TBL {16'hea60, 16'hdc86, 16'hcd10, 16'hbd9a, 16'hae24, \
                  16'h9eae, 16'h8f38, 16'h7fc2, 16'h704c, 16'h60d6, \
                  16'h5160, 16'h41ea, 16'h3274, 16'h22fe, 16'h1388, \
                  16'h0271}
// release rate in ms, code 7 first
`define RLS_MS_TBL {16'h03e8, 16'h01f4, 16'h00fa, 16'h0064, \
                    16'h0032, 16'h0019, 16'h000a, 16'h0005}
// hold time in ms, code 7 first; code 7 is indefinite
`define HOLD_MS_TBL {16'hffff, 16'h07d0, 16'h03e8, 16'h01f4, \
                     16'h00fa, 16'h0064, 16'h000a, 16'h0000}
`define HOLD_INF_CODE    3'h7
`define L0_ATK_MIN_CODE  4'h3
`define DWELL0_US        16'h0000
// threshold in mV
`define TH_BAT_BASE_MV   16'h0a8c
`define TH_PWR_BASE_MV   16'h157c
`define TH_STEP_MV       16'h0032
`define TH_BAT_MAX       8'h38
`define TH_PWR_MAX       8'hd2
`endif

// *** sim/blcr_config_regs_tb.sv ***
`timescale 1ns/10ps
module blcr_config_regs_tb;
  import blcr_pkg::*;
  localparam int MSC = 10;
  localparam logic [3:0] S_ATK = 4'h0, S_STP = 4'h1, S_RRT = 4'h2;
  localparam logic [3:0] S_MAX = 4'h3, S_TH = 4'h4, S_HLD = 4'h5;
  localparam logic [3:0] S_HINF = 4'h6, S_EN = 4'h7, S_DW = 4'h8;
  localparam logic [3:0] S_L0 = 4'h9, S_L0V = 4'ha, S_SRC = 4'hb;
  typedef struct {
    blcr_addr_t  a;
    logic [7:0]  wd;
    logic [7:0]  rb;
    logic [3:0]  sel;
    blcr_val16_t ex;
  } blcr_tb_row_t;
  localparam int N_ROWS = 49;
  // write value, expected readback, then one decoded output to compare
  blcr_tb_row_t rows [N_ROWS] = '{
    '{8'ha8,8'h1f,8'h1e,S_ATK,16'h0005}, '{8'ha8,8'h22,8'h22,S_ATK,16'h000a},
    '{8'ha8,8'h44,8'h44,S_ATK,16'h0014}, '{8'ha8,8'h66,8'h66,S_ATK,16'h0032},
    '{8'ha8,8'h88,8'h88,S_ATK,16'h0064}, '{8'ha8,8'haa,8'haa,S_ATK,16'h00c8},
    '{8'ha8,8'hcc,8'hcc,S_ATK,16'h01f4}, '{8'ha8,8'hee,8'hee,S_ATK,16'h03e8},
    '{8'ha8,8'he0,8'he0,S_STP,16'h0271}, '{8'ha8,8'h02,8'h02,S_STP,16'h1388},
    '{8'ha8,8'h1e,8'h1e,S_STP,16'hea60}, '{8'ha8,8'h06,8'h06,S_STP,16'h3274},
    '{8'hac,8'h1f,8'h1f,S_RRT,16'h0005}, '{8'hac,8'h20,8'h20,S_RRT,16'h000a},
    '{8'hac,8'h40,8'h40,S_RRT,16'h0019}, '{8'hac,8'h60,8'h60,S_RRT,16'h0032},
    '{8'hac,8'h80,8'h80,S_RRT,16'h0064}, '{8'hac,8'ha0,8'ha0,S_RRT,16'h00fa},
    '{8'hac,8'hc0,8'hc0,S_RRT,16'h01f4}, '{8'hac,8'hff,8'hff,S_RRT,16'h03e8},
    '{8'hac,8'hff,8'hff,S_MAX,16'h001f}, '{8'hac,8'h00,8'h00,S_MAX,16'h0000},
    '{8'hb0,8'h00,8'h00,S_TH,16'h0a8c},  '{8'hb0,8'h38,8'h38,S_TH,16'h157c},
    '{8'hb0,8'h39,8'h39,S_TH,16'h0000},  '{8'hb0,8'hff,8'hff,S_TH,16'h0000},
    '{8'hfc,8'h01,8'h01,S_SRC,16'h0001}, '{8'hb0,8'h00,8'h00,S_TH,16'h157c},
    '{8'hb0,8'h5a,8'h5a,S_TH,16'h2710},  '{8'hb0,8'hd2,8'hd2,S_TH,16'h3e80},
    '{8'hb0,8'hd3,8'hd3,S_TH,16'h0000},  '{8'hfc,8'h00,8'h00,S_SRC,16'h0000},
    '{8'hb4,8'h0f,8'h00,S_HLD,16'h0000}, '{8'hb4,8'h20,8'h20,S_HLD,16'h000a},
    '{8'hb4,8'h40,8'h40,S_HLD,16'h0064}, '{8'hb4,8'h60,8'h60,S_HLD,16'h00fa},
    '{8'hb4,8'h80,8'h80,S_HLD,16'h01f4}, '{8'hb4,8'ha0,8'ha0,S_HLD,16'h03e8},
    '{8'hb4,8'hc0,8'hc0,S_HLD,16'h07d0}, '{8'hb4,8'he0,8'he0,S_HLD,16'hffff},
    '{8'hb4,8'he0,8'he0,S_HINF,16'h0001}, '{8'hb4,8'h30,8'h30,S_EN,16'h0000},
    '{8'hb4,8'h20,8'h20,S_EN,16'h0001},  '{8'hb8,8'hff,8'hfe,S_DW,16'h0000},
    '{8'hb8,8'h06,8'h06,S_L0,16'h3274},  '{8'hb8,8'h1e,8'h1e,S_L0,16'hea60},
    '{8'hb8,8'h04,8'h04,S_L0,16'h0000},  '{8'hb8,8'h04,8'h04,S_L0V,16'h0000},
    '{8'hb8,8'h06,8'h06,S_L0V,16'h0001}};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  blcr_addr_t  paddr;
  blcr_data_t  pwdata, prdata;
  logic [3:0]  pstrb;
  blcr_db_t    atten_request, atten_limited_db;
  logic [10:0] lvl1_attack_hus;
  blcr_val16_t lvl1_release_step_e4db, lvl1_release_rate_ms;
  blcr_val16_t lvl1_threshold_mv, lvl1_hold_time_ms;
  blcr_val16_t lvl0_dwell_time_us, lvl0_attack_step_e4db;
  logic [4:0]  lvl1_max_atten_db;
  logic        lvl1_hold_infinite, lvl1_enable, lvl0_attack_step_valid;
  logic        monitor_source_select, hold_clear, half_us_tick, ms_tick;
  int          errors, n_checks;

  blcr_config_regs #(.MS_CYCLES(MSC)) blcr_config_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .atten_request(atten_request), .lvl1_attack_hus(lvl1_attack_hus),
    .lvl1_release_step_e4db(lvl1_release_step_e4db),
    .lvl1_release_rate_ms(lvl1_release_rate_ms),
    .lvl1_max_atten_db(lvl1_max_atten_db),
    .atten_limited_db(atten_limited_db),
    .lvl1_threshold_mv(lvl1_threshold_mv),
    .lvl1_hold_time_ms(lvl1_hold_time_ms),
    .lvl1_hold_infinite(lvl1_hold_infinite), .lvl1_enable(lvl1_enable),
    .lvl0_dwell_time_us(lvl0_dwell_time_us),
    .lvl0_attack_step_e4db(lvl0_attack_step_e4db),
    .lvl0_attack_step_valid(lvl0_attack_step_valid),
    .monitor_source_select(monitor_source_select), .hold_clear(hold_clear),
    .half_us_tick(half_us_tick), .ms_tick(ms_tick));

  always #10 pclk = ~pclk;

  task automatic give_verdict();
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  // one full apb transfer; every change lands just after a rising edge
  task automatic apb(input logic wr, input blcr_addr_t a, input logic [7:0] d,
                     input logic [3:0] s, output blcr_data_t rd,
                     output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      errors++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr8(input blcr_addr_t a, input logic [7:0] d,
                     input logic e = 1'b0, input logic [3:0] s = 4'hf);
    blcr_data_t r;
    logic       x;
    apb(1'b1, a, d, s, r, x);
    chk(x, e);
  endtask

  task automatic rd8(input blcr_addr_t a, input blcr_data_t v,
                     input logic e = 1'b0);
    blcr_data_t r;
    logic       x;
    apb(1'b0, a, 8'h00, 4'h0, r, x);
    chk(r, v);
    chk(x, e);
  endtask

  // decoded outputs follow one edge after the register edge
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  function automatic blcr_val16_t get_out(input logic [3:0] s);
    case (s)
      S_ATK:   return {5'h00, lvl1_attack_hus};
      S_STP:   return lvl1_release_step_e4db;
      S_RRT:   return lvl1_release_rate_ms;
      S_MAX:   return {11'h000, lvl1_max_atten_db};
      S_TH:    return lvl1_threshold_mv;
      S_HLD:   return lvl1_hold_time_ms;
      S_HINF:  return {15'h0000, lvl1_hold_infinite};
      S_EN:    return {15'h0000, lvl1_enable};
      S_DW:    return lvl0_dwell_time_us;
      S_L0:    return lvl0_attack_step_e4db;
      S_L0V:   return {15'h0000, lvl0_attack_step_valid};
      default: return {15'h0000, monitor_source_select};
    endcase
  endfunction

  // cycles between two pulses of one tick, bounded at both waits
  task automatic period(input logic ms, input int exp);
    int k;
    // step off the edge so a tick launched there is not seen early
    #1;
    for (k = 0; k < 200 && (ms ? ms_tick : half_us_tick) !== 1'b1; k++) begin
      @(posedge pclk);
      #1;
    end
    for (k = 1; k < 200; k++) begin
      @(posedge pclk);
      #1;
      if ((ms ? ms_tick : half_us_tick) === 1'b1) break;
    end
    chk(k, exp);
  endtask

  initial begin
    logic [7:0] rv [5];
    int         hc;
    rv = '{8'h06, 8'h38, 8'h40, 8'h20, 8'h02};
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    atten_request = 6'h00;
    errors = 0;
    n_checks = 0;
    repeat (12) @(posedge pclk);
    chk(lvl1_enable, 1'b0);
    presetn <= 1'b1;
    settle();
    chk(lvl1_enable, 1'b1);
    chk(lvl1_threshold_mv, 16'h0000);
    chk(lvl1_attack_hus, 11'h005);
    chk(lvl1_max_atten_db, 5'h18);
    for (int i = 0; i < 5; i++) rd8(8'ha8 + 8'(4 * i), {24'h00_0000, rv[i]});
    foreach (rows[i]) begin
      wr8(rows[i].a, rows[i].wd);
      rd8(rows[i].a, {24'h00_0000, rows[i].rb});
      settle();
      chk(get_out(rows[i].sel), rows[i].ex);
    end
    // clamp against a programmed maximum of 12 dB, then with level 1 off
    wr8(8'hac, 8'h0c);
    settle();
    @(posedge pclk);
    atten_request <= 6'h14;
    #1;
    chk(atten_limited_db, 6'h0c);
    @(posedge pclk);
    atten_request <= 6'h05;
    #1;
    chk(atten_limited_db, 6'h05);
    wr8(8'hb4, 8'h30);
    settle();
    chk(atten_limited_db, 6'h00);
    // refused and ignored accesses leave the register untouched
    rd8(8'h00, 32'h0000_0000, 1'b1);
    wr8(8'ha9, 8'hff, 1'b1);
    wr8(8'hf8, 8'hff, 1'b1);
    wr8(8'ha8, 8'hff, 1'b0, 4'he);
    rd8(8'ha8, 32'h0000_0006);
    // status word: threshold, enable, indefinite hold, level 0 valid
    wr8(8'hb0, 8'h38);
    wr8(8'hb4, 8'he0);
    settle();
    rd8(8'hf8, 32'h0007_157c);
    wr8(8'hfc, 8'h02);
    hc = 0;
    #1;
    for (int i = 0; i < 5; i++) begin
      if (hold_clear === 1'b1) hc++;
      @(posedge pclk);
      #1;
    end
    chk(hc, 1);
    rd8(8'hfc, 32'h0000_0000);
    period(1'b0, 25);
    period(1'b1, MSC);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd8(8'hb4, 32'h0000_0020);
    settle();
    chk(lvl1_hold_time_ms, 16'h000a);
    chk(lvl1_enable, 1'b1);
    give_verdict();
  end
endmodule
